/* File: rtl/gdio_defines.svh */
// Offsets, field positions, reset values for the GPIO port.
// Assumes a byte-addressed Wishbone bus with 32-bit data.
`ifndef GDIO_DEFINES_SVH
`define GDIO_DEFINES_SVH

`define GDIO_WIDTH          8
`define GDIO_OFS_OUT        8'h00
`define GDIO_OFS_DIR        8'h04
`define GDIO_OFS_IN         8'h08
`define GDIO_OFS_SFC        8'h0C
`define GDIO_OFS_OUT_SET    8'h10
`define GDIO_OFS_OUT_CLR    8'h14
`define GDIO_OFS_DIR_SET    8'h18
`define GDIO_OFS_DIR_CLR    8'h1C
`define GDIO_PUD_BIT        2
`define GDIO_RST_OUT        8'h00
`define GDIO_RST_DIR        8'h00
`define GDIO_RST_PUD        1'b0

`endif

/* File: rtl/gdio_pkg.sv */
// Types shared by the GPIO port files.
// Assumes nothing of its surroundings.
package gdio_pkg;

    // Bus slave states, one-hot
    typedef enum logic [1:0] {
        GDIO_ST_IDLE = 2'b01,
        GDIO_ST_ACK  = 2'b10
    } gdio_bus_state_t;

endpackage : gdio_pkg

/* File: rtl/gdio_sync.sv */
// Two-stage input synchronizer for the pad levels.
// Assumes one system clock; pads may change at any time.
`timescale 1ns/1ps
`default_nettype none

`include "gdio_defines.svh"

module gdio_sync #(
    parameter int WIDTH = `GDIO_WIDTH
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic [WIDTH-1:0] d_i,
    output logic      [WIDTH-1:0] q_o
);
    import gdio_pkg::*;

    logic [WIDTH-1:0] hold_reg;
    logic [WIDTH-1:0] q_reg;

    // Stage one closes on the falling edge, like a high-transparent latch
    always_ff @(negedge clk_i)
    begin
        if (rst_i)
            hold_reg <= '0;
        else
            hold_reg <= d_i;
    end

    // Stage two captures on the next rising edge
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            q_reg <= '0;
        else
            q_reg <= hold_reg;
    end

    assign q_o = q_reg;

endmodule : gdio_sync
`default_nettype wire

/* File: rtl/gdio_pin_mux.sv */
// Per-pin mode logic: drive enable, drive value and pull-up.
// Assumes registered control bits and a level reset input.
`timescale 1ns/1ps
`default_nettype none

module gdio_pin_mux (
    input  wire logic rst_i,
    input  wire logic dir_i,
    input  wire logic out_i,
    input  wire logic pud_i,
    input  wire logic alt_en_i,
    input  wire logic alt_dir_i,
    input  wire logic alt_out_i,
    output logic      pad_o,
    output logic      pad_oe_n_o,
    output logic      pullup_en_o
);
    import gdio_pkg::*;

    logic dir_eff;
    logic out_eff;

    // Alternate function takes only its own pin
    assign dir_eff = alt_en_i ? alt_dir_i : dir_i;
    assign out_eff = alt_en_i ? alt_out_i : out_i;

    // Direction one drives, zero listens; reset floats without a clock
    assign pad_oe_n_o = rst_i | ~dir_eff;
    assign pad_o = dir_eff & out_eff;

    // Pull-up only for an input holding one, unless disabled or in reset
    assign pullup_en_o = ~rst_i & ~pud_i & ~dir_eff & out_eff;

endmodule : gdio_pin_mux
`default_nettype wire

/* File: rtl/gdio_port.sv */
// GPIO port top: Wishbone register slave, pin cells, input path.
// Assumes classic Wishbone single cycles and external pad wiring
// that resolves the level from pad_o, pad_oe_n_o and pullup_en_o.
//
// Design decisions made here: register access over Wishbone and the register addresses.
`timescale 1ns/1ps
`default_nettype none

`include "gdio_defines.svh"

// How it works
// - The port has a read-write output value register, a read-write direction register and a read-only sampled input register.
// - Setting the global pull-up disable turns every pull-up off whatever the pin bits say.
// - A direction bit of one makes the pin an output and zero makes it an input.
// - An input pin whose output value bit is one gets its pull-up, which goes off on zero or on output.
// - During reset every pin floats, without needing a clock.
// - An output pin drives high for an output value of one and low for zero.
// - Direction, value and pull-up disable map to float, pull-up, float, drive low or drive high.
// - The sampled input bit shows the synchronized pad level in any direction, except on pins clamped low in deep sleep.
// - The pad passes a falling-edge stage and then a rising-edge stage before it is read.
// - A written value shows at the sampled input one clock later, so software waits one instruction.
// - Set and clear writes change only the pins whose bits are one.
// - Pins given to an alternate function leave the other pins of the port untouched.
// - Pull-ups are off while reset is held.
// - In deep sleep the digital input is clamped low, except on pins enabled as external interrupts.
module gdio_port #(
    parameter int WIDTH = `GDIO_WIDTH
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             wb_cyc_i,
    input  wire logic             wb_stb_i,
    input  wire logic             wb_we_i,
    input  wire logic [7:0]       wb_adr_i,
    input  wire logic [3:0]       wb_sel_i,
    input  wire logic [31:0]      wb_dat_i,
    output logic      [31:0]      wb_dat_o,
    output logic                  wb_ack_o,
    input  wire logic [WIDTH-1:0] pad_i,
    output logic      [WIDTH-1:0] pad_o,
    output logic      [WIDTH-1:0] pad_oe_n_o,
    output logic      [WIDTH-1:0] pullup_en_o,
    input  wire logic [WIDTH-1:0] alt_en_i,
    input  wire logic [WIDTH-1:0] alt_dir_i,
    input  wire logic [WIDTH-1:0] alt_out_i,
    input  wire logic             sleep_i,
    input  wire logic [WIDTH-1:0] ext_int_en_i
);
    import gdio_pkg::*;

    // State of the block outside the input synchronizer
    typedef struct packed {
        gdio_bus_state_t  bus_st;
        logic [WIDTH-1:0] out_val;
        logic [WIDTH-1:0] dir;
        logic             global_pullup_disable;
        logic [31:0]      rdata;
    } gdio_state_t;

    localparam gdio_state_t GDIO_RESET = '{
        bus_st:  GDIO_ST_IDLE,
        out_val: WIDTH'(`GDIO_RST_OUT),
        dir:     WIDTH'(`GDIO_RST_DIR),
        global_pullup_disable:     `GDIO_RST_PUD,
        rdata:   32'h0000_0000
    };

    gdio_state_t      st_reg;
    gdio_state_t      st_next;
    logic             bus_req;
    logic             wr_fire;
    logic [WIDTH-1:0] wdata;
    logic [31:0]      rd_mux;
    logic [WIDTH-1:0] din_clamped;
    logic [WIDTH-1:0] sampled_in;
    logic [7:0]       sfc_read;

    // Bus request qualifiers
    assign bus_req = wb_cyc_i & wb_stb_i;
    assign wr_fire = bus_req & wb_we_i & wb_sel_i[0]
                   & (st_reg.bus_st == GDIO_ST_ACK);
    assign wdata   = wb_dat_i[WIDTH-1:0];

    // Control byte: only the pull-up disable bit is live
    always_comb
    begin
        sfc_read = 8'h00;
        sfc_read[`GDIO_PUD_BIT] = st_reg.global_pullup_disable;
    end

    // Read data select; unmapped and write-only offsets read zero
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        case (wb_adr_i)
            `GDIO_OFS_OUT:
                rd_mux[WIDTH-1:0] = st_reg.out_val;
            `GDIO_OFS_DIR:
                rd_mux[WIDTH-1:0] = st_reg.dir;
            `GDIO_OFS_IN:
                rd_mux[WIDTH-1:0] = sampled_in;
            `GDIO_OFS_SFC:
                rd_mux[7:0] = sfc_read;
            default:
                rd_mux = 32'h0000_0000;
        endcase
    end

    // Next state: bus handshake and register writes
    always_comb
    begin
        st_next = st_reg;
        case (st_reg.bus_st)
            GDIO_ST_IDLE:
            begin
                if (bus_req)
                begin
                    st_next.bus_st = GDIO_ST_ACK;
                    st_next.rdata  = rd_mux;
                end
            end
            GDIO_ST_ACK:
            begin
                st_next.bus_st = GDIO_ST_IDLE;
                if (wr_fire)
                begin
                    case (wb_adr_i)
                        `GDIO_OFS_OUT:
                            st_next.out_val = wdata;
                        `GDIO_OFS_DIR:
                            st_next.dir = wdata;
                        `GDIO_OFS_SFC:
                            st_next.global_pullup_disable = wb_dat_i[`GDIO_PUD_BIT];
                        `GDIO_OFS_OUT_SET:
                            st_next.out_val = st_reg.out_val | wdata;
                        `GDIO_OFS_OUT_CLR:
                            st_next.out_val = st_reg.out_val & ~wdata;
                        `GDIO_OFS_DIR_SET:
                            st_next.dir = st_reg.dir | wdata;
                        `GDIO_OFS_DIR_CLR:
                            st_next.dir = st_reg.dir & ~wdata;
                        default:
                            st_next.bus_st = GDIO_ST_IDLE;
                    endcase
                end
            end
            default:
                st_next.bus_st = GDIO_ST_IDLE;
        endcase
        if (rst_i)
            st_next = GDIO_RESET;
    end

    // State register
    always_ff @(posedge clk_i)
    begin
        st_reg <= st_next;
    end

    // Bus outputs
    assign wb_ack_o = (st_reg.bus_st == GDIO_ST_ACK);
    assign wb_dat_o = st_reg.rdata;

    // One pin cell per bit
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++)
        begin : g_pin
            gdio_pin_mux u_pin (
                .rst_i       (rst_i),
                .dir_i       (st_reg.dir[gi]),
                .out_i       (st_reg.out_val[gi]),
                .pud_i       (st_reg.global_pullup_disable),
                .alt_en_i    (alt_en_i[gi]),
                .alt_dir_i   (alt_dir_i[gi]),
                .alt_out_i   (alt_out_i[gi]),
                .pad_o       (pad_o[gi]),
                .pad_oe_n_o  (pad_oe_n_o[gi]),
                .pullup_en_o (pullup_en_o[gi])
            );
        end
    endgenerate

    // Deep sleep clamps the input low unless the pin wakes the part
    assign din_clamped = pad_i & ~({WIDTH{sleep_i}} & ~ext_int_en_i);

    // Input synchronizer; a written level returns one clock later
    gdio_sync #(
        .WIDTH (WIDTH)
    ) u_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   (din_clamped),
        .q_o   (sampled_in)
    );

    // Checks on the design's own behaviour
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // A request that finds the slave idle
    sequence idle_req_s;
        bus_req && (st_reg.bus_st == GDIO_ST_IDLE);
    endsequence

    // A write that lands on one offset
    sequence wr_at_s(logic [7:0] ofs);
        wr_fire && (wb_adr_i == ofs);
    endsequence

    // A read accepted at one offset
    sequence rd_at_s(logic [7:0] ofs);
        idle_req_s ##0 (!wb_we_i && (wb_adr_i == ofs));
    endsequence

    // A read of the sampled input register
    sequence rd_in_s;
        rd_at_s(`GDIO_OFS_IN);
    endsequence

    // Acknowledge answers each request with exactly one cycle
    ack_single_pulse_a: assert property (
        idle_req_s |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not a single-cycle pulse");

    ack_cause_a: assert property (
        wb_ack_o |-> $past(bus_req && (st_reg.bus_st == GDIO_ST_IDLE)))
        else $error("ack without a request");

    // Reset floats every pin, drops pull-ups and clears the registers
    reset_float_a: assert property (
        @(posedge clk_i) disable iff (1'b0)
        rst_i |-> (&pad_oe_n_o))
        else $error("pin driven during reset");

    reset_pull_off_a: assert property (
        @(posedge clk_i) disable iff (1'b0)
        rst_i |-> (pullup_en_o == '0))
        else $error("pull-up on during reset");

    reset_clears_a: assert property (
        @(posedge clk_i) disable iff (1'b0)
        rst_i |=> (st_reg.out_val == '0) && (st_reg.dir == '0)
                  && !st_reg.global_pullup_disable && !wb_ack_o)
        else $error("registers not cleared by reset");

    // Pins kept for general use follow the mode table
    pud_kills_pull_a: assert property (
        st_reg.global_pullup_disable |-> (pullup_en_o == '0))
        else $error("pull-up on while disabled");

    dir_enable_a: assert property (
        (((~pad_oe_n_o) ^ st_reg.dir) & ~alt_en_i) == '0)
        else $error("drive enable does not follow direction");

    drive_level_a: assert property (
        ((pad_o ^ st_reg.out_val) & st_reg.dir & ~alt_en_i) == '0)
        else $error("driven level does not follow value");

    pull_mode_a: assert property (
        ((pullup_en_o ^ (~st_reg.dir & st_reg.out_val & {WIDTH{~st_reg.global_pullup_disable}}))
         & ~alt_en_i) == '0)
        else $error("pull-up mode mismatch");

    // Alternate pins use the same table with their own controls
    alt_isolate_a: assert property (
        ((pad_o ^ (alt_dir_i & alt_out_i)) & alt_en_i) == '0)
        else $error("alternate pin level wrong");

    alt_enable_a: assert property (
        ((pad_oe_n_o ^ ~alt_dir_i) & alt_en_i) == '0)
        else $error("alternate drive enable wrong");

    alt_pull_a: assert property (
        ((pullup_en_o ^ (~alt_dir_i & alt_out_i & {WIDTH{~st_reg.global_pullup_disable}}))
         & alt_en_i) == '0)
        else $error("alternate pull-up wrong");

    // Plain writes replace a register; the input register ignores writes
    out_write_a: assert property (
        wr_at_s(`GDIO_OFS_OUT) |=> st_reg.out_val == $past(wdata))
        else $error("output value write lost");

    dir_write_a: assert property (
        wr_at_s(`GDIO_OFS_DIR) |=> st_reg.dir == $past(wdata))
        else $error("direction write lost");

    pud_write_a: assert property (
        wr_at_s(`GDIO_OFS_SFC) |=> st_reg.global_pullup_disable == $past(wb_dat_i[`GDIO_PUD_BIT]))
        else $error("pull-up disable write lost");

    input_ro_a: assert property (
        wr_at_s(`GDIO_OFS_IN)
        |=> $stable(st_reg.out_val) && $stable(st_reg.dir) && $stable(st_reg.global_pullup_disable))
        else $error("input register write changed state");

    sel_gate_a: assert property (
        idle_req_s ##0 (wb_we_i && !wb_sel_i[0])
        |=> ##1 $stable(st_reg.out_val) && $stable(st_reg.dir) && $stable(st_reg.global_pullup_disable))
        else $error("write without lane select changed state");

    // Set and clear writes touch only the pins written with one
    set_only_a: assert property (
        wr_at_s(`GDIO_OFS_OUT_SET)
        |=> st_reg.out_val == ($past(st_reg.out_val) | $past(wdata)))
        else $error("set write touched other pins");

    out_clear_a: assert property (
        wr_at_s(`GDIO_OFS_OUT_CLR)
        |=> st_reg.out_val == ($past(st_reg.out_val) & ~$past(wdata)))
        else $error("clear write touched other pins");

    dir_set_a: assert property (
        wr_at_s(`GDIO_OFS_DIR_SET)
        |=> st_reg.dir == ($past(st_reg.dir) | $past(wdata)))
        else $error("set write touched other pins");

    dir_clear_a: assert property (
        wr_at_s(`GDIO_OFS_DIR_CLR)
        |=> st_reg.dir == ($past(st_reg.dir) & ~$past(wdata)))
        else $error("clear write touched other pins");

    // Read data carries the addressed register and zero elsewhere
    input_read_a: assert property (
        rd_in_s |=> wb_ack_o && (wb_dat_o[WIDTH-1:0] == $past(sampled_in)))
        else $error("input read returns wrong value");

    sfc_read_a: assert property (
        rd_at_s(`GDIO_OFS_SFC) |=> wb_dat_o[`GDIO_PUD_BIT] == $past(st_reg.global_pullup_disable))
        else $error("pull-up disable read wrong");

    upper_zero_a: assert property (
        idle_req_s |=> (wb_dat_o[31:WIDTH] == '0))
        else $error("read data above the port width not zero");

    write_only_zero_a: assert property (
        idle_req_s ##0 (wb_adr_i >= `GDIO_OFS_OUT_SET)
        |=> (wb_dat_o == '0))
        else $error("write-only offset reads nonzero");

    // Deep sleep clamps every pin that cannot wake the part
    sleep_clamp_a: assert property (
        sleep_i[*3] |-> ((sampled_in & ~ext_int_en_i) == '0))
        else $error("input not clamped in sleep");

endmodule : gdio_port
`default_nettype wire

/* File: bench/gdio_pad_model.sv */
// Pad model: resolves each pad level from the port drivers and the board.
// Assumes the bench drives the board side; undriven, unpulled pads toggle.
`timescale 1ns/1ps
`default_nettype none

module gdio_pad_model (
    input  wire logic       clk_i,
    input  wire logic [7:0] drv_i,
    input  wire logic [7:0] oe_n_i,
    input  wire logic [7:0] pu_i,
    input  wire logic [7:0] ext_en_i,
    input  wire logic [7:0] ext_val_i,
    output logic      [7:0] level_o
);
    logic [7:0] float_reg = 8'h55;

    // Floating pads change every cycle so no level is settled by chance
    always @(posedge clk_i)
    begin
        float_reg <= ~float_reg;
    end

    // Port drive wins, then the board, then the pull-up
    always_comb
    begin
        for (int i = 0; i < 8; i++)
        begin
            if (!oe_n_i[i])
                level_o[i] = drv_i[i];
            else if (ext_en_i[i])
                level_o[i] = ext_val_i[i];
            else if (pu_i[i])
                level_o[i] = 1'b1;
            else
                level_o[i] = float_reg[i];
        end
    end
endmodule : gdio_pad_model
`default_nettype wire

/* File: bench/general_digital_io_port_bench.sv */
// Self-checking bench for the GPIO port: bus tasks, random configs, pads.
// Assumes the pad model closes the loop from pad outputs back to pad_i.
`timescale 1ns/1ps
`default_nettype none
`include "gdio_defines.svh"

module general_digital_io_port_bench;
    logic        clk_i, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, slp = 1'b0;
    logic [7:0]  adr = 8'h00, ee = 8'h00, ev = 8'h00, ae = 8'h00, ad = 8'h00, ao = 8'h00;
    logic [7:0]  ie = 8'h00, d, o, mk, lvl_w, drv, oe_n, pu;
    logic [31:0] wd = 32'h0, rd_w, rdata;
    logic [15:0] m;
    logic        p, ack;
    logic [3:0]  sel = 4'h0, bsel = 4'hF;
    int          miscompares = 0, checked = 0;

    gdio_port i_gdio_port (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(rd_w),
        .wb_ack_o(ack), .pad_i(lvl_w), .pad_o(drv), .pad_oe_n_o(oe_n), .pullup_en_o(pu),
        .alt_en_i(ae), .alt_dir_i(ad), .alt_out_i(ao), .sleep_i(slp), .ext_int_en_i(ie));
    gdio_pad_model i_gdio_pad_model (.clk_i(clk_i), .drv_i(drv), .oe_n_i(oe_n), .pu_i(pu),
        .ext_en_i(ee), .ext_val_i(ev), .level_o(lvl_w));

    // Clock at 10 MHz
    initial
    begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    // Watchdog well beyond the expected run length
    initial
    begin
        #2000000;
        miscompares++;
        results();
    end

    task automatic results;
        if (miscompares == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : results

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Classic single cycle; entered just after a rising edge, waits for ack
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] dat);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wd <= dat;
        sel <= bsel;
        do
        begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        rdata = rd_w;
        if (n >= 20)
        begin
            miscompares++;
            results();
        end
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk_i);
    endtask : bus

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rdata, exp);
    endtask : rdchk

    // Reconfigure only through float, then pull-up or drive low, never diagonally
    task automatic cfg(input logic [7:0] nd, input logic [7:0] no, input logic np);
        bus(1'b1, `GDIO_OFS_DIR, 32'h0);
        bus(1'b1, `GDIO_OFS_OUT, 32'h0);
        bus(1'b1, `GDIO_OFS_SFC, {29'h0, np, 2'h0});
        bus(1'b1, `GDIO_OFS_OUT, {24'h0, no});
        bus(1'b1, `GDIO_OFS_DIR, {24'h0, nd});
    endtask : cfg

    // Expected {oe_n, drive, pull-up} from the mode table
    function automatic logic [31:0] pads(input logic [7:0] fd, fo, input logic fp);
        return {8'h00, ~fd, fd & fo, ~fd & fo & {8{~fp}}};
    endfunction : pads

    // Expected {known mask, level} of the pads
    function automatic logic [15:0] lvl(input logic [7:0] fd, fo, fe, fv, input logic fp);
        logic [7:0] fu;
        fu = ~fd & fo & {8{~fp}};
        return {fd | fe | fu, (fd & fo) | (~fd & fe & fv) | (~fd & ~fe & fu)};
    endfunction : lvl

    // Main sequence
    initial
    begin
        void'($urandom(41118));
        repeat (12) @(posedge clk_i);
        chk({16'h0, oe_n, pu}, 32'h0000FF00);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rdchk(`GDIO_OFS_OUT, 32'h0);
        rdchk(`GDIO_OFS_DIR, 32'h0);
        rdchk(`GDIO_OFS_SFC, 32'h0);
        rdchk(8'h20, 32'h0);
        for (int k = 0; k < 40; k++)
        begin
            d = (k < 2) ? 8'h00 : 8'($urandom);
            o = (k < 2) ? 8'hFF : 8'($urandom);
            p = (k == 1) ? 1'b1 : (k == 0) ? 1'b0 : 1'($urandom);
            cfg(d, o, p);
            ee <= 8'($urandom);
            ev <= 8'($urandom);
            chk({8'h0, oe_n, drv, pu}, pads(d, o, p));
            rdchk(`GDIO_OFS_OUT, {24'h0, o});
            rdchk(`GDIO_OFS_DIR, {24'h0, d});
            rdchk(`GDIO_OFS_SFC, {29'h0, p, 2'h0});
            m = lvl(d, o, ee, ev, p);
            bus(1'b0, `GDIO_OFS_IN, 32'h0);
            chk(rdata & {24'hFFFFFF, m[15:8]}, {24'h0, m[7:0] & m[15:8]});
            mk = 8'($urandom);
            bus(1'b1, `GDIO_OFS_OUT_SET + 8'(4 * (k % 4)), {24'h0, mk});
            o = (k % 4 == 0) ? (o | mk) : (k % 4 == 1) ? (o & ~mk) : o;
            d = (k % 4 == 2) ? (d | mk) : (k % 4 == 3) ? (d & ~mk) : d;
            rdchk(`GDIO_OFS_OUT, {24'h0, o});
            rdchk(`GDIO_OFS_DIR, {24'h0, d});
            rdchk(`GDIO_OFS_OUT_SET + 8'(4 * (k % 4)), 32'h0);
            ae <= 8'($urandom);
            ad <= 8'($urandom);
            ao <= 8'($urandom);
            @(posedge clk_i);
            chk({8'h0, oe_n, drv, pu}, pads((ae & ad) | (~ae & d), (ae & ao) | (~ae & o), p));
            ae <= 8'h00;
            ie <= 8'($urandom);
            slp <= 1'b1;
            repeat (2) @(posedge clk_i);
            m = lvl(d, o, ee, ev, p);
            bus(1'b0, `GDIO_OFS_IN, 32'h0);
            chk({24'h0, rdata[7:0] & (m[15:8] | ~ie)}, {24'h0, m[7:0] & ie & m[15:8]});
            slp <= 1'b0;
        end
        cfg(8'hFF, 8'hA5, 1'b0);
        bus(1'b1, `GDIO_OFS_OUT, 32'h5A);
        rdchk(`GDIO_OFS_IN, 32'h5A);
        bsel = 4'hE;
        bus(1'b1, `GDIO_OFS_OUT, 32'h00);
        bsel = 4'hF;
        rdchk(`GDIO_OFS_OUT, 32'h5A);
        bus(1'b1, `GDIO_OFS_IN, 32'hFF);
        rdchk(`GDIO_OFS_IN, 32'h5A);
        cfg(8'h0F, 8'hFF, 1'b0);
        rst_i <= 1'b1;
        #1;
        chk({16'h0, oe_n, pu}, 32'h0000FF00);
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rdchk(`GDIO_OFS_DIR, 32'h0);
        results();
    end
endmodule : general_digital_io_port_bench
`default_nettype wire
